/* verilog/rca_pkg.sv */
// shared constants and types for the small 8-bit core datapath
`default_nettype none
package rca_pkg;
    // =====================================================
    // program side
    localparam int INSTR_W = 12;
    localparam int PROG_WORDS_SMALL = 512;
    localparam int PROG_WORDS_LARGE = 2048;
    localparam logic [10:0] RESET_VEC = 11'h000;
    localparam logic [11:0] NOP_WORD = 12'h000;
    // =====================================================
    // data side
    localparam int DATA_W = 8;
    localparam int DATA_WORDS = 32;
    localparam int STACK_DEPTH = 2;
    localparam logic [4:0] ADR_INDIRECT = 5'h00;
    localparam logic [4:0] ADR_PCL = 5'h02;
    localparam logic [4:0] ADR_STATUS = 5'h03;
    localparam logic [4:0] ADR_FSR = 5'h04;
    // =====================================================
    // status layout and reset values
    localparam int FLG_C = 0;
    localparam int FLG_NIBBLE = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_PA_LO = 5;
    localparam int FLG_PA_HI = 6;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] FSR_RST = 8'h00;
    localparam logic [7:0] ACC_RST = 8'h00;
    // =====================================================
    // the 33 operations
    typedef enum logic [5:0] {
        OP_NOP, OP_OPTION, OP_SLEEP, OP_CLRWDT, OP_TRIS, OP_MOVWF, OP_CLRW,
        OP_CLRF, OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF, OP_XORWF, OP_ADDWF,
        OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ, OP_RRF, OP_RLF, OP_SWAPF,
        OP_INCFSZ, OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS, OP_RETLW, OP_CALL,
        OP_GOTO, OP_MOVLW, OP_IORLW, OP_ANDLW, OP_XORLW
    } rca_op_e;
    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic nibble_flag;
    } rca_alu_s;
endpackage
`default_nettype wire

/* verilog/rca_core.sv */
// two-stage fetch/execute core with 8-bit arith_logic_unit and file registers
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - every instruction takes one cycle; flow changes and skips take two
// - thirty-three instructions, each exactly one program word
// - instruction word is 12 bits, fetched whole in one cycle
// - fetch of the next word overlaps execution of the current one
// - program space is 512 or 2048 words, held outside the core and fetched over prog_addr/prog_data
// - program fetch and data access use separate, independent paths
// - special_function_registers and program counter live in data space
// - file registers reachable directly from instruction or via pointer
// - arith_logic_unit is 8 bits: add, subtract, shift and logic
// - arithmetic treats operands as two's complement
// - two-operand ops combine accumulator with file register or literal
// - single-operand ops work on accumulator or a file register
// - accumulator is 8 bits and has no data address
// - carry, nibble_flag and zero update according to the instruction
// - on subtraction carry and nibble_flag mean no borrow when set
module rca_core #(
    parameter int PROG_WORDS = rca_pkg::PROG_WORDS_LARGE,
    parameter int PROG_AW = $clog2(PROG_WORDS)
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    output logic [PROG_AW-1:0] prog_addr,
    input wire logic [11:0] prog_data,
    output logic [7:0] acc_value,
    output logic [7:0] status_value,
    output logic [7:0] fsr_value
);
    // =====================================================
    // state
    logic [PROG_AW-1:0] pc_reg, pc_next, pc_inc, br_target;
    logic [11:0] ir_reg, ir_next;
    logic [7:0] acc_reg, acc_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] fsr_reg, fsr_next;
    logic [7:0] ram_reg [rca_pkg::DATA_WORDS];
    logic [7:0] ram_next [rca_pkg::DATA_WORDS];
    logic [PROG_AW-1:0] stk_reg [rca_pkg::STACK_DEPTH];
    logic [PROG_AW-1:0] stk_next [rca_pkg::STACK_DEPTH];
    rca_pkg::rca_op_e op;
    rca_pkg::rca_alu_s alu;
    logic [4:0] eff;
    logic [1:0] page;
    logic [7:0] fval, lit, bmask;
    logic [8:0] sum9, diff9;
    logic [4:0] nib5, dnib5;
    logic upd_c, upd_nibble, upd_z, wr_res, to_f, jump, skip;

    // prog_addr is the fetch port, data storage is internal
    assign prog_addr = pc_reg;
    assign acc_value = acc_reg;
    assign status_value = status_reg;
    assign fsr_value = fsr_reg;

    // =====================================================
    // decode of one 12-bit word into one of 33 operations
    function automatic rca_pkg::rca_op_e decode(input logic [11:0] w);
        rca_pkg::rca_op_e d;
        d = rca_pkg::OP_NOP;
        case (w[11:8])
            4'h4: d = rca_pkg::OP_BCF;
            4'h5: d = rca_pkg::OP_BSF;
            4'h6: d = rca_pkg::OP_BTFSC;
            4'h7: d = rca_pkg::OP_BTFSS;
            4'h8: d = rca_pkg::OP_RETLW;
            4'h9: d = rca_pkg::OP_CALL;
            4'ha, 4'hb: d = rca_pkg::OP_GOTO;
            4'hc: d = rca_pkg::OP_MOVLW;
            4'hd: d = rca_pkg::OP_IORLW;
            4'he: d = rca_pkg::OP_ANDLW;
            4'hf: d = rca_pkg::OP_XORLW;
            default: begin
                case (w[9:6])
                    4'h0: begin
                        if (w[5]) begin
                            d = rca_pkg::OP_MOVWF;
                        end else begin
                            case (w[4:0])
                                5'h02: d = rca_pkg::OP_OPTION;
                                5'h03: d = rca_pkg::OP_SLEEP;
                                5'h04: d = rca_pkg::OP_CLRWDT;
                                5'h05, 5'h06, 5'h07: d = rca_pkg::OP_TRIS;
                                default: d = rca_pkg::OP_NOP;
                            endcase
                        end
                    end
                    4'h1: d = w[5] ? rca_pkg::OP_CLRF : rca_pkg::OP_CLRW;
                    4'h2: d = rca_pkg::OP_SUBWF;
                    4'h3: d = rca_pkg::OP_DECF;
                    4'h4: d = rca_pkg::OP_IORWF;
                    4'h5: d = rca_pkg::OP_ANDWF;
                    4'h6: d = rca_pkg::OP_XORWF;
                    4'h7: d = rca_pkg::OP_ADDWF;
                    4'h8: d = rca_pkg::OP_MOVF;
                    4'h9: d = rca_pkg::OP_COMF;
                    4'ha: d = rca_pkg::OP_INCF;
                    4'hb: d = rca_pkg::OP_DECFSZ;
                    4'hc: d = rca_pkg::OP_RRF;
                    4'hd: d = rca_pkg::OP_RLF;
                    4'he: d = rca_pkg::OP_SWAPF;
                    default: d = rca_pkg::OP_INCFSZ;
                endcase
            end
        endcase
        return d;
    endfunction

    // =====================================================
    // operand fetch from data space
    always_comb begin
        op = decode(ir_reg);
        lit = ir_reg[7:0];
        page = status_reg[rca_pkg::FLG_PA_HI:rca_pkg::FLG_PA_LO];
        bmask = 8'h01 << ir_reg[7:5];
        // address 0 redirects through the pointer register
        eff = (ir_reg[4:0] == rca_pkg::ADR_INDIRECT) ? fsr_reg[4:0] : ir_reg[4:0];
        case (eff)
            rca_pkg::ADR_INDIRECT: fval = 8'h00;
            rca_pkg::ADR_PCL: fval = pc_reg[7:0];
            rca_pkg::ADR_STATUS: fval = status_reg;
            rca_pkg::ADR_FSR: fval = fsr_reg;
            default: fval = ram_reg[eff];
        endcase
        // two's complement add and subtract, subtract as f + ~w + 1
        sum9 = {1'b0, fval} + {1'b0, acc_reg};
        nib5 = {1'b0, fval[3:0]} + {1'b0, acc_reg[3:0]};
        diff9 = {1'b0, fval} + {1'b0, ~acc_reg} + 9'h001;
        dnib5 = {1'b0, fval[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
        pc_inc = PROG_AW'(pc_reg + 1'b1);
    end

    // =====================================================
    // execute stage and next-state
    always_comb begin
        acc_next = acc_reg;
        status_next = status_reg;
        fsr_next = fsr_reg;
        ram_next = ram_reg;
        stk_next = stk_reg;
        pc_next = pc_inc;
        ir_next = prog_data;
        alu.res = fval;
        alu.c = status_reg[rca_pkg::FLG_C];
        alu.nibble_flag = status_reg[rca_pkg::FLG_NIBBLE];
        upd_c = 1'b0;
        upd_nibble = 1'b0;
        upd_z = 1'b0;
        wr_res = 1'b0;
        to_f = ir_reg[5];
        jump = 1'b0;
        skip = 1'b0;
        br_target = pc_reg;
        unique case (op)
            rca_pkg::OP_ADDWF: begin
                alu = '{res: sum9[7:0], c: sum9[8], nibble_flag: nib5[4]};
                {upd_c, upd_nibble, upd_z, wr_res} = 4'hf;
            end
            rca_pkg::OP_SUBWF: begin
                alu = '{res: diff9[7:0], c: diff9[8], nibble_flag: dnib5[4]};
                {upd_c, upd_nibble, upd_z, wr_res} = 4'hf;
            end
            rca_pkg::OP_ANDWF: {alu.res, upd_z, wr_res} = {fval & acc_reg, 2'h3};
            rca_pkg::OP_IORWF: {alu.res, upd_z, wr_res} = {fval | acc_reg, 2'h3};
            rca_pkg::OP_XORWF: {alu.res, upd_z, wr_res} = {fval ^ acc_reg, 2'h3};
            // single-operand group, result to accumulator or register
            rca_pkg::OP_COMF: {alu.res, upd_z, wr_res} = {~fval, 2'h3};
            rca_pkg::OP_DECF: {alu.res, upd_z, wr_res} = {fval - 8'h01, 2'h3};
            rca_pkg::OP_INCF: {alu.res, upd_z, wr_res} = {fval + 8'h01, 2'h3};
            rca_pkg::OP_MOVF: {upd_z, wr_res} = 2'h3;
            rca_pkg::OP_MOVWF: {alu.res, wr_res} = {acc_reg, 1'b1};
            rca_pkg::OP_CLRF, rca_pkg::OP_CLRW: {alu.res, upd_z, wr_res} = {8'h00, 2'h3};
            rca_pkg::OP_DECFSZ: begin
                {alu.res, wr_res} = {fval - 8'h01, 1'b1};
                skip = (alu.res == 8'h00);
            end
            rca_pkg::OP_INCFSZ: begin
                {alu.res, wr_res} = {fval + 8'h01, 1'b1};
                skip = (alu.res == 8'h00);
            end
            // shifts rotate through carry
            rca_pkg::OP_RRF: begin
                alu.res = {status_reg[rca_pkg::FLG_C], fval[7:1]};
                alu.c = fval[0];
                {upd_c, wr_res} = 2'h3;
            end
            rca_pkg::OP_RLF: begin
                alu.res = {fval[6:0], status_reg[rca_pkg::FLG_C]};
                alu.c = fval[7];
                {upd_c, wr_res} = 2'h3;
            end
            rca_pkg::OP_SWAPF: {alu.res, wr_res} = {fval[3:0], fval[7:4], 1'b1};
            rca_pkg::OP_BCF: {alu.res, wr_res, to_f} = {fval & ~bmask, 2'h3};
            rca_pkg::OP_BSF: {alu.res, wr_res, to_f} = {fval | bmask, 2'h3};
            rca_pkg::OP_BTFSC: skip = ((fval & bmask) == 8'h00);
            rca_pkg::OP_BTFSS: skip = ((fval & bmask) != 8'h00);
            // literal group works against the accumulator
            rca_pkg::OP_MOVLW: {alu.res, wr_res, to_f} = {lit, 2'h2};
            rca_pkg::OP_IORLW: {alu.res, upd_z, wr_res, to_f} = {lit | acc_reg, 3'h6};
            rca_pkg::OP_ANDLW: {alu.res, upd_z, wr_res, to_f} = {lit & acc_reg, 3'h6};
            rca_pkg::OP_XORLW: {alu.res, upd_z, wr_res, to_f} = {lit ^ acc_reg, 3'h6};
            rca_pkg::OP_RETLW: begin
                acc_next = lit;
                jump = 1'b1;
                br_target = stk_reg[0];
                stk_next[0] = stk_reg[1];
            end
            rca_pkg::OP_CALL: begin
                jump = 1'b1;
                br_target = PROG_AW'({page, 1'b0, lit});
                stk_next[1] = stk_reg[0];
                stk_next[0] = pc_reg;
            end
            rca_pkg::OP_GOTO: begin
                jump = 1'b1;
                br_target = PROG_AW'({page, ir_reg[8:0]});
            end
            default: begin
            end
        endcase
        // accumulator is reached here when to_f is clear; RETLW loads it directly above
        if (wr_res && !to_f) begin
            acc_next = alu.res;
        end else if (wr_res) begin
            case (eff)
                rca_pkg::ADR_INDIRECT: begin
                end
                rca_pkg::ADR_PCL: begin
                    jump = 1'b1;
                    br_target = PROG_AW'({page, 1'b0, alu.res});
                end
                rca_pkg::ADR_STATUS: status_next = alu.res;
                rca_pkg::ADR_FSR: fsr_next = alu.res;
                default: ram_next[eff] = alu.res;
            endcase
        end
        // flag updates win over a plain write to the status register
        if (upd_c) status_next[rca_pkg::FLG_C] = alu.c;
        if (upd_nibble) status_next[rca_pkg::FLG_NIBBLE] = alu.nibble_flag;
        if (upd_z) status_next[rca_pkg::FLG_Z] = (alu.res == 8'h00);
        if (jump) pc_next = br_target;
        if (jump || skip) ir_next = rca_pkg::NOP_WORD;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pc_reg <= rca_pkg::RESET_VEC[PROG_AW-1:0];
            ir_reg <= rca_pkg::NOP_WORD;
            acc_reg <= rca_pkg::ACC_RST;
            status_reg <= rca_pkg::STATUS_RST;
            fsr_reg <= rca_pkg::FSR_RST;
            ram_reg <= '{default: 8'h00};
            stk_reg <= '{default: '0};
        end else begin
            pc_reg <= pc_next;
            ir_reg <= ir_next;
            acc_reg <= acc_next;
            status_reg <= status_next;
            fsr_reg <= fsr_next;
            ram_reg <= ram_next;
            stk_reg <= stk_next;
        end
    end

    // =====================================================
    // checks
    property p_pipe_step;
        @(posedge sys_clk) disable iff (sys_rst)
        !sys_rst && !jump |=> prog_addr == $past(pc_inc);
    endproperty
    a_pipe_step: assert property (p_pipe_step) else $error("fetch did not advance");

    property p_whole_word;
        @(posedge sys_clk) disable iff (sys_rst)
        !sys_rst && !(jump || skip) |=> ir_reg == $past(prog_data);
    endproperty
    a_whole_word: assert property (p_whole_word) else $error("word not latched");

    property p_flush;
        @(posedge sys_clk) disable iff (sys_rst)
        (jump || skip) |=> ir_reg == rca_pkg::NOP_WORD && prog_addr == $past(pc_next);
    endproperty
    a_flush: assert property (p_flush) else $error("prefetch not discarded");

    property p_goto_two;
        @(posedge sys_clk) disable iff (sys_rst)
        op == rca_pkg::OP_GOTO |=> op == rca_pkg::OP_NOP
            ##1 prog_addr == PROG_AW'($past(br_target, 2) + 1'b1);
    endproperty
    a_goto_two: assert property (p_goto_two) else $error("goto timing wrong");

    property p_add_carry;
        @(posedge sys_clk) disable iff (sys_rst)
        op == rca_pkg::OP_ADDWF |=> status_reg[rca_pkg::FLG_C] == ($past(fval) > ~$past(acc_reg))
            && status_reg[rca_pkg::FLG_NIBBLE] == ($past(fval[3:0]) > ~$past(acc_reg[3:0]));
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_sub_borrow;
        @(posedge sys_clk) disable iff (sys_rst)
        op == rca_pkg::OP_SUBWF |=> status_reg[rca_pkg::FLG_C] == ($past(fval) >= $past(acc_reg))
            && status_reg[rca_pkg::FLG_NIBBLE] == ($past(fval[3:0]) >= $past(acc_reg[3:0]));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow wrong");

    property p_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        upd_z |=> status_reg[rca_pkg::FLG_Z] == ($past(alu.res) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_literal;
        @(posedge sys_clk) disable iff (sys_rst)
        op == rca_pkg::OP_MOVLW |=> acc_reg == $past(ir_reg[7:0]);
    endproperty
    a_literal: assert property (p_literal) else $error("literal not loaded");

    property p_pcl_map;
        @(posedge sys_clk) disable iff (sys_rst)
        op == rca_pkg::OP_MOVF && !ir_reg[5] && ir_reg[4:0] == rca_pkg::ADR_PCL
            |=> acc_reg == $past(pc_reg[7:0]);
    endproperty
    a_pcl_map: assert property (p_pcl_map) else $error("pc not readable");

    property p_indirect;
        @(posedge sys_clk) disable iff (sys_rst)
        op == rca_pkg::OP_MOVWF && ir_reg[4:0] == rca_pkg::ADR_INDIRECT
            && fsr_reg[4:0] > rca_pkg::ADR_FSR |=> ram_reg[$past(fsr_reg[4:0])] == $past(acc_reg);
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect write lost");
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the two-stage core datapath, fed from a bench program store
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // =====================================================
    // signals and design under test
    logic sys_clk;
    logic sys_rst;
    logic [10:0] prog_addr;
    logic [11:0] prog_data;
    logic [7:0] acc_value;
    logic [7:0] status_value;
    logic [7:0] fsr_value;
    logic [11:0] rom [0:2047];
    logic [11:0] pq [$];
    logic [11:0] ops [7];
    logic [10:0] exp_pa [6];
    logic [7:0] exp_acc [6];
    logic [31:0] seed;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] e;
    int k;
    int mismatches;
    int n_tests;

    rca_core #(
        .PROG_WORDS(rca_pkg::PROG_WORDS_LARGE)
    ) i_rca_core (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .prog_addr(prog_addr),
        .prog_data(prog_data),
        .acc_value(acc_value),
        .status_value(status_value),
        .fsr_value(fsr_value)
    );

    // asynchronous program store: word valid in the same cycle as its address
    assign prog_data = rom[prog_addr];

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // =====================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // expected accumulator in [15:8] and status in [7:0] for one operation on f=a, w=b
    function automatic logic [15:0] alu_exp(input int op, input logic [7:0] fa,
                                            input logic [7:0] wb);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] r;
        logic [2:0] f;
        s = {1'b0, fa} + {1'b0, wb};
        n = {1'b0, fa[3:0]} + {1'b0, wb[3:0]};
        r = 8'h00;
        f = 3'h0;
        case (op)
            0: begin
                r = s[7:0];
                f = {r == 8'h00, n[4], s[8]};
            end
            1: begin
                r = fa - wb;
                f = {r == 8'h00, fa[3:0] >= wb[3:0], fa >= wb};
            end
            2: r = fa & wb;
            3: r = fa | wb;
            4: r = fa ^ wb;
            5: r = {1'b0, fa[7:1]};
            default: r = {fa[6:0], 1'b0};
        endcase
        if (op >= 2 && op <= 4) begin
            f = {r == 8'h00, 2'b00};
        end
        if (op == 5) begin
            f = {2'b00, fa[0]};
        end
        if (op == 6) begin
            f = {2'b00, fa[7]};
        end
        return {r, 5'h00, f};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // loads the program under reset; returns in the time step of the release edge
    task automatic restart();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        for (int i = 0; i < 2048; i++) begin
            rom[i] <= (i < pq.size()) ? pq[i] : rca_pkg::NOP_WORD;
        end
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask

    // =====================================================
    // watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end

    // =====================================================
    // tests
    initial begin
        sys_rst = 1'b1;
        mismatches = 0;
        n_tests = 0;
        seed = 32'h48361666;
        foreach (rom[i]) rom[i] = rca_pkg::NOP_WORD;
        ops = '{12'h1c8, 12'h088, 12'h148, 12'h108, 12'h188, 12'h308, 12'h348};

        // jump discards the prefetched word and costs one extra cycle
        pq = '{12'hc11, 12'ha05, 12'hcff, 12'hcff, 12'hcff, 12'hc3c, 12'ha06};
        exp_pa = '{11'h001, 11'h002, 11'h005, 11'h006, 11'h007, 11'h006};
        exp_acc = '{8'h00, 8'h11, 8'h11, 8'h11, 8'h3c, 8'h3c};
        restart();
        #1;
        check("reset addr", 16'(prog_addr), 16'h0000);
        check("reset acc", 16'(acc_value), 16'(rca_pkg::ACC_RST));
        check("reset status", 16'(status_value), 16'(rca_pkg::STATUS_RST));
        check("reset fsr", 16'(fsr_value), 16'(rca_pkg::FSR_RST));
        for (int c = 0; c < 6; c++) begin
            @(posedge sys_clk);
            #1;
            check("fetch addr", 16'(prog_addr), 16'(exp_pa[c]));
            check("flow acc", 16'(acc_value), 16'(exp_acc[c]));
        end
        $display("test flow done");

        // each of the seven operations in ops with corner operands first, then random ones
        for (int r = 0; r < 28; r++) begin
            k = r % 7;
            seed = xs(seed);
            a = seed[7:0];
            b = seed[15:8];
            if (r < 7) begin
                a = 8'hff;
                b = 8'h01;
            end else if (r < 14) begin
                a = 8'h10;
                b = 8'h01;
            end
            pq = '{{4'hc, a}, 12'h028, {4'hc, b}, ops[k], 12'ha04};
            restart();
            repeat (8) @(posedge sys_clk);
            #1;
            e = alu_exp(k, a, b);
            check("alu acc", 16'(acc_value), 16'(e[15:8]));
            check("alu status", 16'(status_value), 16'(e[7:0]));
        end
        $display("test alu done");

        // program counter read, pointer write and indirect store, then add
        for (int r = 0; r < 4; r++) begin
            seed = xs(seed);
            a = (r == 0) ? 8'hff : (r == 1) ? 8'h0f : seed[7:0];
            pq = '{12'h202, 12'h02a, 12'hc09, 12'h024, {4'hc, a}, 12'h020, 12'h040,
                   12'h209, 12'h1ca, 12'ha09};
            restart();
            repeat (14) @(posedge sys_clk);
            #1;
            e = alu_exp(0, a, 8'h01);
            check("pointer", 16'(fsr_value), 16'h0009);
            check("indirect acc", 16'(acc_value), 16'(e[15:8]));
            check("indirect status", 16'(status_value), 16'(e[7:0]));
        end
        $display("test addressing done");

        // call, return with literal, bit set, then a skip over a clear of that register
        for (int r = 0; r < 4; r++) begin
            seed = xs(seed);
            a = (r == 0) ? 8'hf7 : seed[7:0];
            pq = '{12'h907, 12'h02b, 12'h56b, 12'h76b, 12'h06b, 12'h20b, 12'ha06, {4'h8, a}};
            restart();
            repeat (14) @(posedge sys_clk);
            #1;
            check("return acc", 16'(acc_value), 16'(a | 8'h08));
            check("skip status", 16'(status_value), 16'h0000);
        end
        $display("test control done");
        end_of_test();
    end
endmodule
`default_nettype wire
